// *** design/config_option_defines.svh ***
/*
 * Register offsets, configuration word field positions, reset values and
 * timing counts for the configuration option decoder.
 * Assumes a 20 MHz pclk; every time is kept in microseconds.
 */
`ifndef CONFIG_OPTION_DEFINES_SVH
`define CONFIG_OPTION_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ADDR_CFG        8'h00
`define ADDR_CTRL       8'h04
`define ADDR_PORT_DATA  8'h08
`define ADDR_PORT_DIR   8'h0c
`define ADDR_PORT_READ  8'h10
`define ADDR_STATUS     8'h14

// ----------------------------------------------------------------------
// configuration word fields
// ----------------------------------------------------------------------
`define CFG_WIDTH       15
`define CFG_HRC_LSB     0
`define CFG_HRC_MSB     2
`define CFG_DIV4        3
`define CFG_WDT_OFF     4
`define CFG_T0_LRC      5
`define CFG_PIN3_RST    6
`define CFG_PIN4_CLK    7
`define CFG_START_LSB   8
`define CFG_START_MSB   9
`define CFG_WBASE_LSB   10
`define CFG_WBASE_MSB   11
`define CFG_LVR_ON      12
`define CFG_READ_REG    13
`define CFG_OSC_LRC     14

// ----------------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------------
`define CTRL_WDT_EN     0
`define CTRL_LVR_EN     1
`define CTRL_WDT_CLR    2
`define CTRL_TO_CLR     3
`define CFG_RESET       15'h0000
`define CTRL_RESET      2'h0
`define PORT_RESET      6'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_MHZ         20
`define START0_US       4500
`define START1_US       18000
`define START2_US       72000
`define START3_US       288000
`define WBASE0_US       3500
`define WBASE1_US       15000
`define WBASE2_US       60000
`define WBASE3_US       250000
`define START0_CYC      (`START0_US * `CLK_MHZ)
`define START1_CYC      (`START1_US * `CLK_MHZ)
`define START2_CYC      (`START2_US * `CLK_MHZ)
`define START3_CYC      (`START3_US * `CLK_MHZ)
`define WBASE0_CYC      (`WBASE0_US * `CLK_MHZ)
`define WBASE1_CYC      (`WBASE1_US * `CLK_MHZ)
`define WBASE2_CYC      (`WBASE2_US * `CLK_MHZ)
`define WBASE3_CYC      (`WBASE3_US * `CLK_MHZ)

`endif

// *** design/config_option_pkg.sv ***
/*
 * Types and the period selector shared by the decoder files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package config_option_pkg;

    typedef enum logic [3:0] {
        PH_CAPTURE = 4'b0001,
        PH_LOAD    = 4'b0010,
        PH_WAIT    = 4'b0100,
        PH_RUN     = 4'b1000
    } phase_t;

    typedef logic [23:0] period_t;

    function automatic period_t pick_period(input logic [1:0] sel,
                                            input period_t    p0,
                                            input period_t    p1,
                                            input period_t    p2,
                                            input period_t    p3);
        unique case (sel)
            2'h0: pick_period = p0;
            2'h1: pick_period = p1;
            2'h2: pick_period = p2;
            2'h3: pick_period = p3;
        endcase
    endfunction

endpackage

// *** design/timer_if.sv ***
/*
 * Carrier between the decoder and one delay timer.
 * Assumes the controller never loads a period of zero.
 */
`timescale 1ns/1ns
interface timer_if;
    import config_option_pkg::*;
    logic    load;
    logic    stop;
    period_t period;
    logic    busy;
    logic    expired;
    modport ctl (output load, output stop, output period, input busy, input expired);
    modport tmr (input load, input stop, input period, output busy, output expired);
endinterface

// *** design/clk_div.sv ***
/*
 * Instruction clock divider: pclk divided by two or by four.
 * Assumes div4 is steady once the configuration has been captured.
 */
`timescale 1ns/1ns
module clk_div (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic div4,
    output logic      inst_clk
);
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;

    assign cnt_next = cnt_reg + 2'h1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= 2'h0;
            inst_clk <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            inst_clk <= div4 ? cnt_next[1] : cnt_next[0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    div_two_a: assert property (!div4 && $past(!div4) && $past(rst_n)
                                |-> inst_clk != $past(inst_clk))
        else $error("divide by two clock did not toggle");
    div_four_a: assert property (div4 && $past(div4, 4) && $rose(inst_clk)
                                 |-> $past(inst_clk, 2) == 1'b0 && $past(inst_clk, 3))
        else $error("divide by four clock period wrong");
endmodule

// *** design/delay_timer.sv ***
/*
 * One-shot down counter: load starts it, stop or expiry ends it.
 * Assumes the controller drives load only with a nonzero period.
 */
`timescale 1ns/1ns
module delay_timer (
    input  wire logic clk,
    input  wire logic rst_n,
    timer_if.tmr      t
);
    import config_option_pkg::*;

    period_t cnt_reg;
    period_t since_load_reg;
    logic    busy_reg;
    logic    expired_reg;
    logic    at_end;

    assign at_end    = busy_reg && cnt_reg == 24'h0;
    assign t.busy    = busy_reg;
    assign t.expired = expired_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= 24'h0;
            busy_reg <= 1'b0;
        end else if (t.load) begin
            cnt_reg  <= t.period - 24'h1;
            busy_reg <= 1'b1;
        end else if (t.stop || at_end) begin
            busy_reg <= 1'b0;
        end else if (busy_reg) begin
            cnt_reg  <= cnt_reg - 24'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expired_reg <= 1'b0;
        end else begin
            expired_reg <= at_end && !t.load && !t.stop;
        end
    end

    // cycles since the last load, used only by the run length check
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_load_reg <= 24'h0;
        end else begin
            since_load_reg <= t.load ? 24'h1 : since_load_reg + 24'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    timer_end_a: assert property (at_end && !t.load && !t.stop |=> expired_reg && !busy_reg)
        else $error("timer did not expire at count end");
    run_length_a: assert property (at_end |-> since_load_reg == t.period)
        else $error("timer run length differs from its period");
endmodule

// *** design/config_option_decoder.sv ***
/*
 * Configuration option decoder: captures the programmed option word after
 * reset and turns it into clock, watchdog, startup, pin and reset controls,
 * with an APB slave for control and status.
 * Assumes cfg_word is steady from reset and all pin inputs are synchronous.
 */
// Added by the designer: the APB interface to the registers and the register addresses.
//
// Overview of operation
// - instruction clock is oscillator divided by two or four
// - watchdog enabled option lets software switch it
// - watchdog disabled option keeps it always off
// - pin three is I/O or reset input
// - pin four is I/O or instruction clock output
// - hold execution for chosen startup delay
// - watchdog period chosen from four time bases
// - low voltage reset software switched or always on
// - port read gives pins or output data register
`timescale 1ns/1ns
`include "config_option_defines.svh"
module config_option_decoder
    import config_option_pkg::*;
#(
    parameter int unsigned START0_CYCLES = `START0_CYC,
    parameter int unsigned START1_CYCLES = `START1_CYC,
    parameter int unsigned START2_CYCLES = `START2_CYC,
    parameter int unsigned START3_CYCLES = `START3_CYC,
    parameter int unsigned WBASE0_CYCLES = `WBASE0_CYC,
    parameter int unsigned WBASE1_CYCLES = `WBASE1_CYC,
    parameter int unsigned WBASE2_CYCLES = `WBASE2_CYC,
    parameter int unsigned WBASE3_CYCLES = `WBASE3_CYC
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [`CFG_WIDTH-1:0] cfg_word,
    input  wire logic [5:0]            pin_in,
    output logic      [5:0]            pin_out,
    output logic      [5:0]            pin_oe,
    input  wire logic                  external_clock_input,
    input  wire logic                  internal_low_rc_osc,
    output logic                       inst_clk,
    output logic                       cpu_hold,
    output logic                       watchdog_reset,
    output logic                       low_voltage_reset_en,
    output logic                       ext_reset_req,
    output logic                       timer0_tick,
    output logic                       osc_low_sel,
    output logic      [2:0]            hrc_freq_code
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    phase_t                  phase_reg;
    phase_t                  phase_next;
    logic [`CFG_WIDTH-1:0]   cfg_reg;
    logic [1:0]              ctrl_reg;
    logic                    wdt_clear_reg;
    logic                    timeout_reg;
    logic [5:0]              port_data_reg;
    logic [5:0]              port_dir_reg;
    logic [5:0]              port_read_reg;
    logic                    t0_src_reg;
    logic [31:0]             rdata_next;
    logic                    setup;
    logic                    wr_en;
    logic                    wdt_allowed;
    logic                    wdt_run;
    logic                    t0_src_next;

    timer_if st ();
    timer_if wd ();

    delay_timer u_start (.clk(pclk), .rst_n(presetn), .t(st));
    delay_timer u_wdog  (.clk(pclk), .rst_n(presetn), .t(wd));
    clk_div     u_div   (.clk(pclk), .rst_n(presetn), .div4(cfg_reg[`CFG_DIV4]),
                         .inst_clk(inst_clk));

    function automatic logic mapped(input logic [7:0] a);
        mapped = a == `ADDR_CFG || a == `ADDR_CTRL || a == `ADDR_PORT_DATA ||
                 a == `ADDR_PORT_DIR || a == `ADDR_PORT_READ || a == `ADDR_STATUS;
    endfunction

    // ------------------------------------------------------------------
    // startup sequence
    // ------------------------------------------------------------------
    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            PH_CAPTURE: phase_next = PH_LOAD;
            PH_LOAD:    phase_next = PH_WAIT;
            PH_WAIT:    if (st.expired) begin
                phase_next = PH_RUN;
            end
            PH_RUN:     phase_next = PH_RUN;
            default:    phase_next = PH_CAPTURE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= PH_CAPTURE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // option word caught once, right after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= `CFG_RESET;
        end else if (phase_reg == PH_CAPTURE) begin
            cfg_reg <= cfg_word;
        end
    end

    assign st.load   = phase_reg == PH_LOAD;
    assign st.stop   = 1'b0;
    assign st.period = pick_period(cfg_reg[`CFG_START_MSB:`CFG_START_LSB],
                                   24'(START0_CYCLES), 24'(START1_CYCLES),
                                   24'(START2_CYCLES), 24'(START3_CYCLES));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_hold <= 1'b1;
        end else begin
            cpu_hold <= phase_next != PH_RUN;
        end
    end

    // ------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------
    assign wdt_allowed = !cfg_reg[`CFG_WDT_OFF];
    assign wdt_run     = wdt_allowed && ctrl_reg[`CTRL_WDT_EN] && phase_reg == PH_RUN;
    assign wd.load     = wdt_run && (!wd.busy || wdt_clear_reg);
    assign wd.stop     = !wdt_run && wd.busy;
    assign wd.period   = pick_period(cfg_reg[`CFG_WBASE_MSB:`CFG_WBASE_LSB],
                                     24'(WBASE0_CYCLES), 24'(WBASE1_CYCLES),
                                     24'(WBASE2_CYCLES), 24'(WBASE3_CYCLES));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_reset <= 1'b0;
            timeout_reg    <= 1'b0;
        end else begin
            watchdog_reset <= wd.expired;
            if (wd.expired) begin
                timeout_reg <= 1'b1;
            end else if (wr_en && paddr == `ADDR_CTRL && pwdata[`CTRL_TO_CLR]) begin
                timeout_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // pins, resets, clock sources
    // ------------------------------------------------------------------
    assign t0_src_next = cfg_reg[`CFG_T0_LRC] ? internal_low_rc_osc
                                               : external_clock_input;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= `PORT_RESET;
            pin_oe  <= `PORT_RESET;
        end else begin
            pin_out <= port_data_reg;
            pin_oe  <= port_dir_reg;
            if (cfg_reg[`CFG_PIN3_RST]) begin
                pin_oe[3] <= 1'b0;
            end
            if (cfg_reg[`CFG_PIN4_CLK]) begin
                pin_out[4] <= inst_clk;
                pin_oe[4]  <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_reset_req        <= 1'b0;
            low_voltage_reset_en <= 1'b0;
            osc_low_sel          <= 1'b0;
            hrc_freq_code        <= 3'h0;
            port_read_reg        <= 6'h00;
            t0_src_reg           <= 1'b0;
            timer0_tick          <= 1'b0;
        end else begin
            ext_reset_req        <= cfg_reg[`CFG_PIN3_RST] && !pin_in[3];
            low_voltage_reset_en <= cfg_reg[`CFG_LVR_ON] || ctrl_reg[`CTRL_LVR_EN];
            osc_low_sel          <= cfg_reg[`CFG_OSC_LRC];
            hrc_freq_code        <= cfg_reg[`CFG_HRC_MSB:`CFG_HRC_LSB];
            port_read_reg        <= cfg_reg[`CFG_READ_REG] ? port_data_reg : pin_in;
            t0_src_reg           <= t0_src_next;
            timer0_tick          <= t0_src_next && !t0_src_reg;
        end
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready;

    always_comb begin
        rdata_next = 32'h0;
        unique case (paddr)
            `ADDR_CFG:       rdata_next = {17'h0, cfg_reg};
            `ADDR_CTRL:      rdata_next = {30'h0, ctrl_reg};
            `ADDR_PORT_DATA: rdata_next = {26'h0, port_data_reg};
            `ADDR_PORT_DIR:  rdata_next = {26'h0, port_dir_reg};
            `ADDR_PORT_READ: rdata_next = {26'h0, port_read_reg};
            `ADDR_STATUS:    rdata_next = {26'h0, osc_low_sel, ext_reset_req,
                                           low_voltage_reset_en, timeout_reg,
                                           wd.busy, !cpu_hold};
            default:         rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped(paddr);
            if (setup && !pwrite) begin
                prdata <= rdata_next;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg      <= `CTRL_RESET;
            wdt_clear_reg <= 1'b0;
            port_data_reg <= `PORT_RESET;
            port_dir_reg  <= `PORT_RESET;
        end else begin
            wdt_clear_reg <= wr_en && paddr == `ADDR_CTRL && pwdata[`CTRL_WDT_CLR];
            if (wr_en && paddr == `ADDR_CTRL) begin
                ctrl_reg <= pwdata[1:0];
            end
            if (wr_en && paddr == `ADDR_PORT_DATA) begin
                port_data_reg <= pwdata[5:0];
            end
            if (wr_en && paddr == `ADDR_PORT_DIR) begin
                port_dir_reg <= pwdata[5:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence wdt_sw_on_s;
        phase_reg == PH_RUN && wdt_allowed && ctrl_reg[`CTRL_WDT_EN] && !wd.busy;
    endsequence
    sequence wd_fire_s;
        wd.expired ##1 watchdog_reset && timeout_reg;
    endsequence

    wdt_sw_start_a: assert property (wdt_sw_on_s |=> wd.busy)
        else $error("permitted watchdog not started");
    wdt_forced_off_a: assert property (!wdt_allowed |-> !wd.busy && !watchdog_reset)
        else $error("watchdog ran while disabled by option");
    wdt_fire_a: assert property (wd.expired |-> wd_fire_s)
        else $error("watchdog expiry not reported");
    start_hold_a: assert property (phase_reg != PH_RUN |-> ##1 cpu_hold || $past(st.expired))
        else $error("execution released before startup delay");
    start_free_a: assert property (phase_reg == PH_WAIT && st.expired |=> !cpu_hold)
        else $error("execution not released after startup delay");
    pin3_rst_a: assert property (phase_reg == PH_RUN && cfg_reg[`CFG_PIN3_RST] ##1
                                 cfg_reg[`CFG_PIN3_RST]
                                 |-> !pin_oe[3] && ext_reset_req == !$past(pin_in[3]))
        else $error("pin three reset function wrong");
    pin4_clk_a: assert property (phase_reg == PH_RUN && cfg_reg[`CFG_PIN4_CLK]
                                 |=> pin_oe[4] && pin_out[4] == $past(inst_clk))
        else $error("pin four clock output wrong");
    lvr_on_a: assert property (phase_reg == PH_RUN && cfg_reg[`CFG_LVR_ON]
                               |=> low_voltage_reset_en)
        else $error("low voltage reset not forced on");
    port_read_a: assert property (phase_reg == PH_RUN ##1 phase_reg == PH_RUN
                                  |-> port_read_reg == (cfg_reg[`CFG_READ_REG] ?
                                      $past(port_data_reg) : $past(pin_in)))
        else $error("port read source wrong");
    t0_tick_a: assert property (timer0_tick |-> $past(t0_src_next) && !$past(t0_src_next, 2))
        else $error("timer0 tick without source edge");
    osc_sel_a: assert property (phase_reg == PH_RUN |=> osc_low_sel == cfg_reg[`CFG_OSC_LRC]
                                && hrc_freq_code == cfg_reg[`CFG_HRC_MSB:`CFG_HRC_LSB])
        else $error("startup oscillator selection wrong");
endmodule

// *** bench/config_option_decoder_bench.sv ***
/*
 * Self-checking bench for the configuration option decoder: one reset per option word.
 * Assumes the design files are compiled first; delay counts are shortened by parameter.
 */
`timescale 1ns/1ns
`include "config_option_defines.svh"
module config_option_decoder_bench;
    import config_option_pkg::*;
    typedef struct {
        logic [14:0] cfg;
        int          ns;
        int          nw;
    } row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [14:0] cfg_word = 15'h0000;
    logic [5:0]  pin_in = 6'h00;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe;
    logic        external_clock_input = 1'b0;
    logic        internal_low_rc_osc = 1'b0;
    logic        inst_clk;
    logic        cpu_hold;
    logic        watchdog_reset;
    logic        low_voltage_reset_en;
    logic        ext_reset_req;
    logic        timer0_tick;
    logic        osc_low_sel;
    logic [2:0]  hrc_freq_code;
    int          n_errors = 0;
    int          total_checks = 0;
    row_t        rows [4];
    always #25 pclk = ~pclk;
    // only watchdog base zero is shortened; every row that runs the watchdog uses it
    config_option_decoder #(.START0_CYCLES(20), .START1_CYCLES(40), .START2_CYCLES(60),
        .START3_CYCLES(80), .WBASE0_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg_word(cfg_word), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .external_clock_input(external_clock_input),
        .internal_low_rc_osc(internal_low_rc_osc), .inst_clk(inst_clk), .cpu_hold(cpu_hold),
        .watchdog_reset(watchdog_reset), .low_voltage_reset_en(low_voltage_reset_en),
        .ext_reset_req(ext_reset_req), .timer0_tick(timer0_tick), .osc_low_sel(osc_low_sel),
        .hrc_freq_code(hrc_freq_code));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk32({31'h0, g}, {31'h0, e});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // counts edges up to the next watchdog pulse, bound when none comes
    task automatic wait_pulse(input int bound, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (watchdog_reset !== 1'b1 && n < bound);
    endtask
    task automatic startup(input int ns);
        int n;
        n = 0;
        while (cpu_hold !== 1'b0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk1(n >= ns + 4 && n <= ns + 7, 1'b1);
    endtask
    task automatic ticks(output int n);
        n = 0;
        repeat (5) begin
            @(posedge pclk);
            if (timer0_tick === 1'b1) n++;
        end
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #(50 * 20000);
        n_errors++;
        wrap_up();
    end
    initial begin
        logic [31:0] rd;
        logic        er;
        logic [14:0] c;
        logic        p;
        int          n;
        int          r;
        rows[0] = '{15'h0000, 20, 20};
        rows[1] = '{15'h71fd, 40, 20};
        rows[2] = '{15'h024a, 60, 20};
        rows[3] = '{15'h23a3, 80, 20};
        for (int i = 0; i < 4; i++) begin
            c = rows[i].cfg;
            presetn <= 1'b0;
            cfg_word <= c;
            tick(3);
            presetn <= 1'b1;
            startup(rows[i].ns);
            chk32(32'(hrc_freq_code), 32'(c[2:0]));
            chk1(osc_low_sel, c[14]);
            r = 0;
            p = inst_clk;
            repeat (16) begin
                @(posedge pclk);
                if (inst_clk === 1'b1 && p === 1'b0) r++;
                p = inst_clk;
            end
            chk32(r, c[3] ? 4 : 8);
            apb(1'b0, `ADDR_CFG, 32'h0, rd, er);
            chk32(rd, {17'h0, c});
            chk1(low_voltage_reset_en, c[12]);
            apb(1'b1, `ADDR_CTRL, 32'h2, rd, er);
            tick(2);
            chk1(low_voltage_reset_en, 1'b1);
            apb(1'b1, `ADDR_CTRL, 32'h1, rd, er);
            tick(2);
            chk1(low_voltage_reset_en, c[12]);
            wait_pulse(400, n);
            if (c[4]) chk32(n, 400);
            else begin
                wait_pulse(400, n);
                chk1(n >= rows[i].nw && n <= rows[i].nw + 2, 1'b1);
                apb(1'b1, `ADDR_CTRL, 32'h0, rd, er);
                tick(2);
                wait_pulse(300, n);
                chk32(n, 300);
            end
            pin_in <= 6'h15;
            apb(1'b1, `ADDR_PORT_DATA, 32'h2a, rd, er);
            apb(1'b1, `ADDR_PORT_DIR, 32'h2f, rd, er);
            tick(2);
            chk32(32'(pin_out & (c[7] ? 6'h2f : 6'h3f)), 32'h2a);
            chk32(32'(pin_oe), 32'(c[6] ? 6'h27 : 6'h2f) | (c[7] ? 32'h10 : 32'h0));
            chk1(ext_reset_req, c[6]);
            p = inst_clk;
            repeat (6) begin
                @(posedge pclk);
                if (c[7]) chk1(pin_out[4], p);
                p = inst_clk;
            end
            apb(1'b0, `ADDR_PORT_READ, 32'h0, rd, er);
            chk32(rd, c[13] ? 32'h2a : 32'h15);
            external_clock_input <= 1'b1;
            ticks(n);
            chk32(n, c[5] ? 0 : 1);
            internal_low_rc_osc <= 1'b1;
            ticks(n);
            chk32(n, c[5] ? 1 : 0);
            external_clock_input <= 1'b0;
            internal_low_rc_osc <= 1'b0;
        end
        // unmapped place and a write to a read-only register
        apb(1'b1, 8'h40, 32'h1, rd, er);
        chk1(er, 1'b1);
        apb(1'b0, 8'h40, 32'h0, rd, er);
        chk1(er, 1'b1);
        chk32(rd, 32'h0);
        apb(1'b1, `ADDR_CFG, 32'h0, rd, er);
        apb(1'b0, `ADDR_CFG, 32'h0, rd, er);
        chk32(rd, 32'h23a3);
        chk1(er, 1'b0);
        // sticky timeout from the last row, then cleared by software
        apb(1'b0, `ADDR_STATUS, 32'h0, rd, er);
        chk32(rd, 32'h05);
        apb(1'b1, `ADDR_CTRL, 32'h8, rd, er);
        apb(1'b0, `ADDR_STATUS, 32'h0, rd, er);
        chk32(rd, 32'h01);
        // reset in mid-run with the watchdog counting
        apb(1'b1, `ADDR_CTRL, 32'h1, rd, er);
        tick(5);
        presetn <= 1'b0;
        tick(2);
        chk1(cpu_hold, 1'b1);
        chk32(32'(pin_oe), 32'h0);
        chk1(pready, 1'b0);
        chk1(inst_clk, 1'b0);
        presetn <= 1'b1;
        startup(80);
        apb(1'b0, `ADDR_CTRL, 32'h0, rd, er);
        chk32(rd, 32'h0);
        wrap_up();
    end
endmodule
